/* File: dv/testbench.sv */
// Self-checking bench for the frame control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, srst = 1'b1, frame_start = 1'b0, line_window = 1'b0, field_parity = 1'b0;
  logic timer_clear_pin = 1'b0, full_vres_pin = 1'b1;
  logic [7:0] line_count = 8'hff, adc_data = 8'h00;
  logic [9:0] vsync_line = 10'h000;
  logic [2:0] cam_sel_pin = 3'h0, shutter_sel_pin = 3'h0;
  logic [1:0] rate_sel_pin = 2'h0, sink_mode = 2'h0;
  logic dac_strobe, pattern_oe_low, pattern_oe_high, pattern_latch, half_line_flag, pixel_window;
  logic frame_selected, field_selected, source_sel_low, source_sel_high, timer_seq_bit_a, timer_seq_bit_b;
  logic shutter, pixel_dropped, pix_out_valid, pix_out_ready;
  logic [14:0] pattern_addr;
  logic [8:0] pixel_count, prev_pc;
  logic [7:0] pix_out_data, prev_lc, exp_byte;
  logic [2:0] frame_rate_counter, fcnt = 3'h0, rot = 3'h0;
  logic [1:0] tstate = 2'h3;
  logic [7:0] notes[$];
  int n_fail = 0, tests_run = 0, cycles = 0, line_len = 0, n_drop = 0;
  bit armed = 0, seen_line = 0;

  vfc_frame_ctl uut (.core_clk, .srst, .frame_start, .line_count, .vsync_line, .line_window, .field_parity,
    .cam_sel_pin, .timer_clear_pin, .rate_sel_pin, .shutter_sel_pin, .full_vres_pin, .adc_data, .dac_strobe,
    .pattern_oe_low, .pattern_oe_high, .pattern_latch, .pattern_addr, .half_line_flag, .pixel_window,
    .pixel_count, .frame_selected, .field_selected, .frame_rate_counter, .source_sel_low, .source_sel_high,
    .timer_seq_bit_a, .timer_seq_bit_b, .shutter, .pixel_dropped, .pix_out_valid, .pix_out_data, .pix_out_ready);
  vfc_sink_model sink (.core_clk, .mode(sink_mode), .ready(pix_out_ready));

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) adc_data <= #1 8'($urandom);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_lb;
    int k;
    k = 0;
    do begin
      tick(1);
      k++;
    end while ({half_line_flag, pixel_window, pixel_count} !== 11'h000 && k < 1000);
  endtask
  function automatic logic [1:0] src_exp(input logic [2:0] c, input logic [2:0] r);
    case (c)
      3'h0: return vfc_pkg::SRC_TEST;
      3'h1, 3'h2, 3'h4: return c[2] ? 2'h3 : c[1] ? 2'h2 : 2'h1;
      3'h7: return 2'(r % 3'h3) + 2'h1;
      default: return r[0] ? (c[2] ? 2'h3 : 2'h2) : (c[0] ? 2'h1 : 2'h2);
    endcase
  endfunction
  function automatic logic [7:0] bar_byte();
    logic [1:0] s;
    logic b;
    s = src_exp(cam_sel_pin, rot);
    case ({half_line_flag, pixel_count[8:7]})
      3'h0: b = tstate[1];
      3'h1: b = tstate[0];
      3'h2: b = s[0];
      3'h4: b = s[1];
      3'h5: b = ^s;
      default: b = 1'b0;
    endcase
    return b ? vfc_pkg::OVERLAY_ONE : vfc_pkg::OVERLAY_ZERO;
  endfunction
  task automatic frame(input logic [1:0] rate);
    logic sel;
    frame_start = 1'b1;
    tick(1);
    frame_start = 1'b0;
    fcnt = fcnt + 3'h1;
    sel = (fcnt & ((3'h1 << rate) - 3'h1)) == 3'h0;
    if (sel) begin
      rot = (rot == 3'h5) ? 3'h0 : rot + 3'h1;
      case (tstate)
        2'h3: tstate = timer_clear_pin ? 2'h2 : 2'h3;
        2'h2: tstate = timer_clear_pin ? 2'h2 : 2'h0;
        2'h0: tstate = 2'h1;
        default: tstate = 2'h3;
      endcase
    end
    tick(2);
    chk(frame_selected === sel && frame_rate_counter === fcnt, "frame choice");
    chk({source_sel_high, source_sel_low} === src_exp(cam_sel_pin, rot), "source");
    chk({timer_seq_bit_a, timer_seq_bit_b} === tstate, "timer state");
  endtask

  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 30000) begin
      n_fail++;
      give_verdict();
    end
    if (srst) begin
      notes.delete();
      armed = 0;
      seen_line = 0;
    end else begin
      if (armed) begin
        chk(dac_strobe === prev_pc[0], "strobe");
        chk({pattern_oe_low, pattern_oe_high} === {~prev_pc[1] & prev_pc[0], &prev_pc[1:0]}, "enables");
        chk(pattern_latch === (&prev_pc[1:0]), "latch");
        chk(pattern_addr === {prev_lc, prev_pc[8:2]}, "address");
      end
      armed = 1;
      prev_pc = pixel_count;
      prev_lc = line_count;
      line_len++;
      if ({half_line_flag, pixel_window, pixel_count} === 11'h000) begin
        if (seen_line) chk(line_len == vfc_pkg::PIX_PER_LINE, "line length");
        seen_line = 1;
        line_len = 0;
      end
      if (pixel_dropped === 1'b1) begin
        n_drop++;
        void'(notes.pop_back());
      end
      if (pix_out_valid === 1'b1 && pix_out_ready === 1'b1) begin
        exp_byte = notes.size() > 0 ? notes.pop_front() : 8'hxx;
        chk(pix_out_data === exp_byte, "stored pixel");
      end
      if ((frame_selected & field_selected & line_window & pixel_window) === 1'b1)
        notes.push_back(vsync_line == vfc_pkg::OVERLAY_LINE ? bar_byte() : adc_data);
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h2a04));
    tick(3);
    srst = 1'b0;
    tick(5);
    chk({timer_seq_bit_a, timer_seq_bit_b, shutter, frame_selected, pix_out_valid} === 5'h18, "reset");
    for (int r = 0; r < 4; r++) begin
      rate_sel_pin = 2'(r);
      tick(6);
      repeat (9) frame(2'(r));
    end
    rate_sel_pin = 2'h0;
    for (int c = 0; c < 8; c++) begin
      cam_sel_pin = 3'(c);
      tick(6);
      repeat (7) frame(2'h0);
    end
    timer_clear_pin = 1'b1;
    tick(6);
    repeat (3) frame(2'h0);
    timer_clear_pin = 1'b0;
    tick(6);
    repeat (4) frame(2'h0);
    for (int i = 0; i < 4; i++) begin
      {full_vres_pin, field_parity} = 2'(i);
      tick(6);
      chk(field_selected === (full_vres_pin | ~field_parity), "field flag");
    end
    {full_vres_pin, field_parity} = 2'h2;
    cam_sel_pin = 3'($urandom);
    vsync_line = vfc_pkg::OVERLAY_LINE;
    sink_mode = 2'h1;
    tick(6);
    line_window = 1'b1;
    tick(1820);
    vsync_line = 10'($urandom_range(262, 18));
    sink_mode = 2'h2;
    tick(500);
    sink_mode = 2'h1;
    tick(1000);
    sink_mode = 2'h0;
    line_window = 1'b0;
    tick(20);
    chk(notes.size() == 0 && n_drop > 0, "buffer drain");
    for (int s = 0; s < 3; s++) begin
      shutter_sel_pin = 3'(s);
      line_count = 8'hff;
      wait_lb();
      line_count = 8'h00;
      line_window = 1'b1;
      tick(2);
      chk(shutter === 1'b1, "shutter start");
      for (int l = 1; l <= vfc_pkg::SHUT_END[s]; l++) begin
        wait_lb();
        line_count = 8'(l);
        tick(2);
        chk(shutter === (l < vfc_pkg::SHUT_END[s]), "shutter end");
      end
    end
    give_verdict();
  end
endmodule

/* File: dv/vfc_sink_model.sv */
// Pixel sink model: takes stored pixels and stalls on command
module vfc_sink_model (
  // Clock
  input wire logic core_clk,
  // Stall mode: 0 always ready, 1 random stalls, 2 blocked
  input wire logic [1:0] mode,
  // Handshake
  output logic ready
);
  timeunit 1ns;
  timeprecision 100ps;
  initial ready = 1'b0;
  always @(posedge core_clk) ready <= #1 (mode == 2'h0) || (mode == 2'h1 && $urandom_range(3) != 0);
endmodule

/* File: include/vfc_buf_if.sv */
// Handshake carrier between the frame control core and its pixel buffer
interface vfc_buf_if;
  logic in_valid;
  logic in_ready;
  logic [7:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [7:0] out_data;
  modport core (output in_valid, output in_data, output out_ready, input in_ready, input out_valid, input out_data);
  modport buffer (input in_valid, input in_data, input out_ready, output in_ready, output out_valid, output out_data);
endinterface

/* File: include/vfc_pkg.sv */
// Constants and types shared by the frame control block
package vfc_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PIX_W = 9;
  localparam int LINE_W = 8;
  localparam int VLINE_W = 10;
  localparam int FRAME_CNT_W = 3;
  localparam int ROT_W = 3;
  localparam int PIN_W = 10;
  // ----------------------------------------
  // Pixel counter partitions and overlay
  // ----------------------------------------
  localparam int PIX_PER_LINE = 910;
  localparam logic [PIX_W-1:0] PIX_BLANK_LAST = 9'h086;
  localparam logic [PIX_W-1:0] PIX_ACTIVE_LAST = 9'h13f;
  localparam logic [VLINE_W-1:0] OVERLAY_LINE = 10'h011;
  localparam logic [7:0] OVERLAY_ONE = 8'hc0;
  localparam logic [7:0] OVERLAY_ZERO = 8'h00;
  // ----------------------------------------
  // Counters and reset values
  // ----------------------------------------
  localparam logic [ROT_W-1:0] ROT_LAST = 3'h5;
  localparam logic [ROT_W-1:0] ROT_RESET = 3'h0;
  localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_RESET = 3'h0;
  localparam logic [PIN_W-1:0] PIN_RESET = 10'h000;
  localparam logic [1:0] TIMER_IDLE_CODE = 2'h3;
  localparam logic [1:0] TIMER_HOLD_CODE = 2'h2;
  localparam logic [1:0] TIMER_ZERO_CODE = 2'h0;
  localparam logic [1:0] TIMER_ONE_CODE = 2'h1;
  // ----------------------------------------
  // Source select codes
  // ----------------------------------------
  localparam logic [1:0] SRC_TEST = 2'h0;
  localparam logic [1:0] SRC_CAM1 = 2'h1;
  localparam logic [1:0] SRC_CAM2 = 2'h2;
  localparam logic [1:0] SRC_CAM3 = 2'h3;
  // ----------------------------------------
  // Shutter end line per jumper setting
  // ----------------------------------------
  localparam logic [LINE_W-1:0] SHUT_END [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {TIMER_IDLE, TIMER_HOLD, TIMER_ZERO, TIMER_ONE} vfc_timer_t;
endpackage

/* File: src/vfc_frame_ctl.sv */
// Frame level control: test pattern readout, frame choice, source rotation, overlay, timer and shutter
module vfc_frame_ctl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Timing from the line logic on this clock
  input wire logic frame_start,
  input wire logic [vfc_pkg::LINE_W-1:0] line_count,
  input wire logic [vfc_pkg::VLINE_W-1:0] vsync_line,
  input wire logic line_window,
  input wire logic field_parity,
  // Pins: camera requests, timer clear, jumpers
  input wire logic [2:0] cam_sel_pin,
  input wire logic timer_clear_pin,
  input wire logic [1:0] rate_sel_pin,
  input wire logic [2:0] shutter_sel_pin,
  input wire logic full_vres_pin,
  // Converter pixel data
  input wire logic [7:0] adc_data,
  // Test pattern readout
  output logic dac_strobe,
  output logic pattern_oe_low,
  output logic pattern_oe_high,
  output logic pattern_latch,
  output logic [vfc_pkg::LINE_W+vfc_pkg::PIX_W-3:0] pattern_addr,
  // Pixel counter state
  output logic half_line_flag,
  output logic pixel_window,
  output logic [vfc_pkg::PIX_W-1:0] pixel_count,
  // Frame and source state
  output logic frame_selected,
  output logic field_selected,
  output logic [vfc_pkg::FRAME_CNT_W-1:0] frame_rate_counter,
  output logic source_sel_low,
  output logic source_sel_high,
  output logic timer_seq_bit_a,
  output logic timer_seq_bit_b,
  output logic shutter,
  output logic pixel_dropped,
  // Stored pixel stream
  output logic pix_out_valid,
  output logic [7:0] pix_out_data,
  input wire logic pix_out_ready
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [1:0] src_pick(input logic [2:0] cams, input logic [2:0] rot);
    logic [1:0] first;
    logic [1:0] last;
    first = cams[0] ? vfc_pkg::SRC_CAM1 : (cams[1] ? vfc_pkg::SRC_CAM2 : vfc_pkg::SRC_CAM3);
    last = cams[2] ? vfc_pkg::SRC_CAM3 : (cams[1] ? vfc_pkg::SRC_CAM2 : vfc_pkg::SRC_CAM1);
    unique case (2'(cams[0]) + 2'(cams[1]) + 2'(cams[2]))
      2'h0: src_pick = vfc_pkg::SRC_TEST;
      2'h1: src_pick = first;
      2'h2: src_pick = rot[0] ? last : first;
      2'h3: src_pick = (rot == 3'h0 || rot == 3'h3) ? vfc_pkg::SRC_CAM1 :
        ((rot == 3'h1 || rot == 3'h4) ? vfc_pkg::SRC_CAM2 : vfc_pkg::SRC_CAM3);
    endcase
  endfunction

  function automatic logic [1:0] timer_code(input vfc_pkg::vfc_timer_t st);
    unique case (st)
      vfc_pkg::TIMER_IDLE: timer_code = vfc_pkg::TIMER_IDLE_CODE;
      vfc_pkg::TIMER_HOLD: timer_code = vfc_pkg::TIMER_HOLD_CODE;
      vfc_pkg::TIMER_ZERO: timer_code = vfc_pkg::TIMER_ZERO_CODE;
      vfc_pkg::TIMER_ONE: timer_code = vfc_pkg::TIMER_ONE_CODE;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [vfc_pkg::PIN_W-1:0] pin_raw;
  logic [vfc_pkg::PIN_W-1:0] pin_s1;
  logic [vfc_pkg::PIN_W-1:0] pin_s2;
  logic [vfc_pkg::PIN_W-1:0] pin_s3;
  logic [vfc_pkg::PIN_W-1:0] pin_clean;
  logic [vfc_pkg::PIN_W-1:0] next_pin_clean;
  logic [2:0] cams;
  logic clear_req;
  logic [1:0] rate_sel;
  logic [2:0] shut_sel;
  logic full_vres;

  assign pin_raw = {full_vres_pin, shutter_sel_pin, rate_sel_pin, timer_clear_pin, cam_sel_pin};
  assign next_pin_clean = (pin_s2 & pin_s3) | (pin_clean & (pin_s2 | pin_s3));
  assign cams = pin_clean[2:0];
  assign clear_req = pin_clean[3];
  assign rate_sel = pin_clean[5:4];
  assign shut_sel = pin_clean[8:6];
  assign full_vres = pin_clean[9];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_s1 <= vfc_pkg::PIN_RESET;
      pin_s2 <= vfc_pkg::PIN_RESET;
      pin_s3 <= vfc_pkg::PIN_RESET;
      pin_clean <= vfc_pkg::PIN_RESET;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_clean <= next_pin_clean;
    end
  end

  // ----------------------------------------
  // Pixel counter
  // ----------------------------------------
  logic part_end;
  logic line_begin;
  logic [vfc_pkg::PIX_W-1:0] next_pixel_count;

  assign part_end = pixel_count == (pixel_window ? vfc_pkg::PIX_ACTIVE_LAST : vfc_pkg::PIX_BLANK_LAST);
  assign line_begin = pixel_count == '0 && !half_line_flag && !pixel_window;
  assign next_pixel_count = part_end ? '0 : pixel_count + 9'h001;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pixel_count <= '0;
      half_line_flag <= 1'b0;
      pixel_window <= 1'b0;
    end else begin
      pixel_count <= next_pixel_count;
      if (part_end) pixel_window <= !pixel_window;
      if (part_end && pixel_window) half_line_flag <= !half_line_flag;
    end
  end

  // ----------------------------------------
  // Test pattern readout
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dac_strobe <= 1'b0;
      pattern_oe_low <= 1'b0;
      pattern_oe_high <= 1'b0;
      pattern_latch <= 1'b0;
      pattern_addr <= '0;
    end else begin
      dac_strobe <= pixel_count[0];
      pattern_oe_low <= !pixel_count[1] && pixel_count[0];
      pattern_oe_high <= pixel_count[1] && pixel_count[0];
      pattern_latch <= pixel_count[1] && pixel_count[0];
      pattern_addr <= {line_count, pixel_count[vfc_pkg::PIX_W-1:2]};
    end
  end

  // ----------------------------------------
  // Frame choice and source rotation
  // ----------------------------------------
  logic [vfc_pkg::FRAME_CNT_W-1:0] next_frame_cnt;
  logic [vfc_pkg::FRAME_CNT_W-1:0] rate_mask;
  logic next_frame_sel;
  logic frame_adv;
  logic [vfc_pkg::ROT_W-1:0] rot;
  logic [vfc_pkg::ROT_W-1:0] next_rot;
  logic [1:0] src;

  assign next_frame_cnt = frame_rate_counter + 3'h1;
  assign rate_mask = 3'((4'h1 << rate_sel) - 4'h1);
  assign next_frame_sel = (next_frame_cnt & rate_mask) == '0;
  assign frame_adv = frame_start && next_frame_sel;
  assign next_rot = (rot == vfc_pkg::ROT_LAST) ? vfc_pkg::ROT_RESET : rot + 3'h1;
  assign src = src_pick(cams, rot);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frame_rate_counter <= vfc_pkg::FRAME_CNT_RESET;
      frame_selected <= 1'b0;
      rot <= vfc_pkg::ROT_RESET;
      source_sel_low <= 1'b0;
      source_sel_high <= 1'b0;
      field_selected <= 1'b0;
    end else begin
      if (frame_start) frame_rate_counter <= next_frame_cnt;
      if (frame_start) frame_selected <= next_frame_sel;
      if (frame_adv) rot <= next_rot;
      source_sel_low <= src[0];
      source_sel_high <= src[1];
      field_selected <= full_vres || !field_parity;
    end
  end

  // ----------------------------------------
  // Timer clear sequence
  // ----------------------------------------
  vfc_pkg::vfc_timer_t tstate;
  vfc_pkg::vfc_timer_t next_tstate;
  logic [1:0] timer_bits;

  assign timer_bits = timer_code(tstate);

  always_comb begin
    next_tstate = tstate;
    unique case (tstate)
      vfc_pkg::TIMER_IDLE: if (clear_req) next_tstate = vfc_pkg::TIMER_HOLD;
      vfc_pkg::TIMER_HOLD: if (!clear_req) next_tstate = vfc_pkg::TIMER_ZERO;
      vfc_pkg::TIMER_ZERO: next_tstate = vfc_pkg::TIMER_ONE;
      vfc_pkg::TIMER_ONE: next_tstate = vfc_pkg::TIMER_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tstate <= vfc_pkg::TIMER_IDLE;
      timer_seq_bit_a <= 1'b1;
      timer_seq_bit_b <= 1'b1;
    end else begin
      if (frame_adv) tstate <= next_tstate;
      timer_seq_bit_a <= timer_bits[1];
      timer_seq_bit_b <= timer_bits[0];
    end
  end

  // ----------------------------------------
  // Overlay bars and pixel gating
  // ----------------------------------------
  logic [2:0] bar_pos;
  logic overlay_line;
  logic overlay_bit;
  logic [7:0] store_data;
  logic store_en;
  vfc_buf_if pbus ();

  assign bar_pos = {half_line_flag, pixel_count[8], pixel_count[7]};
  assign overlay_line = vsync_line == vfc_pkg::OVERLAY_LINE;
  assign overlay_bit = (bar_pos == 3'h0) ? timer_seq_bit_a :
    (bar_pos == 3'h1) ? timer_seq_bit_b :
    (bar_pos == 3'h2) ? source_sel_low :
    (bar_pos == 3'h4) ? source_sel_high :
    (bar_pos == 3'h5) ? (source_sel_low ^ source_sel_high) : 1'b0;
  assign store_data = overlay_line ? (overlay_bit ? vfc_pkg::OVERLAY_ONE : vfc_pkg::OVERLAY_ZERO) : adc_data;
  assign store_en = frame_selected && field_selected && line_window && pixel_window;
  assign pbus.in_valid = store_en;
  assign pbus.in_data = store_data;
  assign pbus.out_ready = pix_out_ready;
  assign pix_out_valid = pbus.out_valid;
  assign pix_out_data = pbus.out_data;

  vfc_pix_buf u_buf (
    .core_clk(core_clk),
    .srst(srst),
    .bus(pbus.buffer)
  );

  // ----------------------------------------
  // Shutter and overflow
  // ----------------------------------------
  logic shut_rise;
  logic shut_fall;

  assign shut_rise = line_begin && line_count == '0 && line_window;
  assign shut_fall = line_begin && line_count == vfc_pkg::SHUT_END[shut_sel];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      shutter <= 1'b0;
      pixel_dropped <= 1'b0;
    end else begin
      if (shut_rise) shutter <= 1'b1;
      else if (shut_fall) shutter <= 1'b0;
      pixel_dropped <= store_en && !pbus.in_ready;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_last_part;
    half_line_flag && pixel_window && pixel_count == vfc_pkg::PIX_ACTIVE_LAST;
  endsequence
  sequence s_adv_when(vfc_pkg::vfc_timer_t st);
    frame_adv && tstate == st;
  endsequence

  a_line_wrap: assert property (s_last_part |=> line_begin)
    else $error("Pixel counter did not restart the line");
  a_enable_split: assert property (!(pattern_oe_low && pattern_oe_high))
    else $error("Pattern register enables overlap");
  a_latch_quarter: assert property ($rose(pattern_latch) && pixel_window |=> !pattern_latch [*3] ##1 pattern_latch)
    else $error("Pattern latch is not quarter rate");
  a_rot_wrap: assert property (frame_adv && rot == vfc_pkg::ROT_LAST |=> rot == vfc_pkg::ROT_RESET)
    else $error("Rotation counter did not wrap");
  a_src_test: assert property (cams == 3'h0 |=> {source_sel_high, source_sel_low} == vfc_pkg::SRC_TEST)
    else $error("Test pattern not chosen without camera requests");
  a_timer_hold: assert property (s_adv_when(vfc_pkg::TIMER_HOLD) and clear_req |=> tstate == vfc_pkg::TIMER_HOLD)
    else $error("Timer left hold while clear still requested");
  a_timer_tail: assert property (s_adv_when(vfc_pkg::TIMER_ZERO) |=> tstate == vfc_pkg::TIMER_ONE ##1
    $rose(timer_seq_bit_b) && !timer_seq_bit_a)
    else $error("Timer did not step from 00 to 01");
  a_store_gate: assert property (!(frame_selected && field_selected && line_window && pixel_window)
    && !pbus.out_valid |=> !pbus.out_valid)
    else $error("Pixel stored outside the digitized window");
  a_overlay_val: assert property (pbus.in_valid && overlay_line |-> pbus.in_data[5:0] == 6'h00
    && pbus.in_data[7] == pbus.in_data[6])
    else $error("Overlay pixel has wrong value");
  a_shutter_rise: assert property (shut_rise |=> shutter)
    else $error("Shutter did not open at line zero");
endmodule

/* File: src/vfc_pix_buf.sv */
// Two-entry pixel buffer with valid and ready on both sides
module vfc_pix_buf (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Buffer side of the carrier
  vfc_buf_if.buffer bus
);
  logic [7:0] head;
  logic [7:0] tail;
  logic [1:0] cnt;
  logic full;
  logic push;
  logic pop;
  logic [1:0] next_cnt;
  logic [7:0] next_head;
  logic out_valid_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign push = bus.in_valid && !full;
  assign pop = bus.out_valid && bus.out_ready;
  assign next_cnt = cnt + 2'(push) - 2'(pop);
  assign next_head = (cnt == 2'h0 || (cnt == 2'h1 && pop)) ? bus.in_data : (pop ? tail : head);
  assign bus.in_ready = !full;
  assign bus.out_valid = out_valid_q;
  assign bus.out_data = head;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt <= 2'h0;
      full <= 1'b0;
      out_valid_q <= 1'b0;
      head <= 8'h00;
      tail <= 8'h00;
    end else begin
      cnt <= next_cnt;
      full <= next_cnt == 2'h2;
      out_valid_q <= next_cnt != 2'h0;
      if (push || pop) head <= next_head;
      if (push) tail <= bus.in_data;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_buf_no_over: assert property (@(posedge core_clk) disable iff (srst) full |-> !push)
    else $error("Buffer accepted a word while full");
  a_buf_order: assert property (@(posedge core_clk) disable iff (srst)
    (cnt == 2'h1 && pop && push) |=> head == $past(bus.in_data))
    else $error("Buffer lost word order");
endmodule
